// ---- rtl/ssl_pkg.sv ----
// Constants, types and register map of the strap sampling and LED drive block.
// How it works
// RULE1: Pins are inputs in reset, outputs after.
// RULE2: Straps sampled whatever hardware/software mode is.
// RULE3: Address strap low gives zero, high one.
// RULE4: Receive LED strap latches into address bit 4.
// RULE5: Receive LED pin then drives its LED.
// RULE6: Collision strap plus speed select pick mode.
// RULE7: Collision strap low selects media independent interface.
// RULE8: Collision strap high selects stream interface.
// RULE9: Collision LED asserted while collisions are seen.
// RULE10: Collision LED held about 70 ms.
// RULE11: Link and transmit LEDs follow link state.
// RULE12: Asserted output level is inverse of strap.
// RULE13: Software reset leaves pins and straps untouched.
// RULE14: Activity strap is address bit 0, link LED.
// RULE15: Board sets speed select low 10M, high 100M.
// RULE16: New collision restarts the stretch interval.
// RULE17: Board pulls every strap pin, never floating.
`default_nettype none
package ssl_pkg;
  // ****************************************************************
  // Pins and timing
  // ****************************************************************
  localparam int unsigned NUM_PINS = 5;
  localparam int unsigned PIN_ACT = 0;
  localparam int unsigned PIN_COLL = 1;
  localparam int unsigned PIN_LINK = 2;
  localparam int unsigned PIN_TX = 3;
  localparam int unsigned PIN_RX = 4;
  localparam longint unsigned CLK_HZ = 64'd50000000;
  localparam longint unsigned MS_PER_S = 64'd1000;
  localparam longint unsigned COLL_STRETCH_MS = 64'd70;
  localparam longint unsigned COLL_STRETCH_CYC = COLL_STRETCH_MS * CLK_HZ / MS_PER_S;
  localparam int CNT_W = 22;
  typedef enum logic [1:0] {SSL_MII_10, SSL_MII_100, SSL_SER_10, SSL_SYM_100} ssl_mode_t;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_STRAP = 8'h00;
  localparam logic [7:0] ADDR_LIVE = 8'h04;
  localparam logic [7:0] ADDR_ISTAT = 8'h08;
  localparam logic [7:0] ADDR_ICLR = 8'h0C;
  localparam logic [7:0] ADDR_IEN = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;
  localparam int STRAP_MODE_LSB = 5;
  localparam int STRAP_DONE_BIT = 7;
  localparam int STRAP_SPEED_BIT = 8;
  localparam int STRAP_HWSW_BIT = 9;
  localparam int LIVE_OE_LSB = 8;
  localparam int NUM_EVT = 3;
  localparam int EVT_COLL = 0;
  localparam int EVT_LINK = 1;
  localparam int EVT_STRAP = 2;
  localparam int CTRL_LED_OFF = 0;
  localparam logic [2:0] IEN_RST = 3'h0;
  localparam logic [2:0] ISTAT_RST = 3'h0;
  localparam logic CTRL_RST = 1'b0;
endpackage
`default_nettype wire

// ---- rtl/ssl_coll_if.sv ----
// Interface between the pin logic and the collision LED stretcher.
`default_nettype none
interface ssl_coll_if;
  logic collision;
  logic ledOn;
  modport stretcher (input collision, output ledOn);
  modport user (output collision, input ledOn);
endinterface
`default_nettype wire

// ---- rtl/ssl_stretch.sv ----
// Collision LED pulse stretcher.
`default_nettype none
module ssl_stretch
  import ssl_pkg::*;
#(
  parameter int unsigned STRETCH_CYCLES = 32'(COLL_STRETCH_CYC)
) (
  input wire logic clk,
  input wire logic reset,
  ssl_coll_if.stretcher cif
);
  localparam logic [CNT_W-1:0] RELOAD = CNT_W'(STRETCH_CYCLES);
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  wire running = (count_q != '0);
  // A collision during a running interval reloads it, so bursts keep the LED lit.
  assign count_d = cif.collision ? RELOAD : (running ? count_q - 1'b1 : count_q); // [RULE10] [RULE16]
  assign cif.ledOn = cif.collision | running; // [RULE9]
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
  AST_RELOAD: assert property (@(posedge clk) disable iff (reset) // [RULE16]
    cif.collision |=> count_q == RELOAD)
    else $error("Stretch counter not reloaded by collision.");
  AST_HOLD: assert property (@(posedge clk) disable iff (reset) // [RULE10]
    (count_q > 1) |=> cif.ledOn)
    else $error("Collision LED dropped before interval ended.");
  AST_EXPIRE: assert property (@(posedge clk) disable iff (reset) // [RULE9]
    (count_q == 1) && !cif.collision ##1 !cif.collision |-> !cif.ledOn)
    else $error("Collision LED lit after interval with no collision.");
endmodule
`default_nettype wire

// ---- rtl/ssl_pin_cell.sv ----
// One multiplexed strap input and LED output pin.
`default_nettype none
module ssl_pin_cell (
  input wire logic clk,
  input wire logic reset,
  input wire logic capture,
  input wire logic driveEn,
  input wire logic ledOn,
  input wire logic pinIn,
  output logic strap_q,
  output logic pinOut_q,
  output logic pinOe_q
);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_q <= 1'b0;
      pinOut_q <= 1'b0;
      pinOe_q <= 1'b0; // [RULE1]
    end else begin
      if (capture) begin
        strap_q <= pinIn; // [RULE3]
      end
      pinOe_q <= driveEn; // [RULE1]
      // Asserted level is the inverse of the strap so the strapped LED lights.
      pinOut_q <= driveEn & (strap_q ^ ledOn); // [RULE12]
    end
  end
endmodule
`default_nettype wire

// ---- rtl/ssl_top.sv ----
// Strap sampling, LED drive and APB register file of the multiplexed PHY pins.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`default_nettype none
module ssl_top
  import ssl_pkg::*;
#(
  parameter int unsigned STRETCH_CYCLES = 32'(COLL_STRETCH_CYC)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [NUM_PINS-1:0] ledIn,
  output logic [NUM_PINS-1:0] ledOut,
  output logic [NUM_PINS-1:0] ledOe,
  input wire logic speedSelect,
  input wire logic modeSelectA,
  input wire logic softReset,
  input wire logic collisionDet,
  input wire logic linkUp,
  input wire logic rxActive,
  output logic [NUM_PINS-1:0] phyAddr,
  output ssl_mode_t ifMode,
  output logic strapDone,
  output logic irq,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ****************************************************************
  // Strap capture
  // ****************************************************************
  // The pins are sampled at the first edge after reset release, which
  // is the only way to catch a level without loading it under reset.
  logic strapDone_q;
  logic speed_q;
  logic modeSel_q;
  ssl_mode_t mode_q;
  ssl_mode_t modeNext;
  logic [NUM_PINS-1:0] strap;
  logic [NUM_PINS-1:0] ledOn;
  logic ledOff_q;
  wire capture = ~strapDone_q; // [RULE2]

  assign modeNext = ledIn[PIN_COLL] ? // [RULE6]
    (speedSelect ? SSL_SYM_100 : SSL_SER_10) : // [RULE8]
    (speedSelect ? SSL_MII_100 : SSL_MII_10); // [RULE7]

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strapDone_q <= 1'b0;
      speed_q <= 1'b0;
      modeSel_q <= 1'b0;
      mode_q <= SSL_MII_10;
    end else if (capture) begin
      strapDone_q <= 1'b1;
      speed_q <= speedSelect;
      modeSel_q <= modeSelectA;
      mode_q <= modeNext; // [RULE6]
    end
  end

  // ****************************************************************
  // LED sources
  // ****************************************************************
  ssl_coll_if cif ();
  assign cif.collision = collisionDet;

  ssl_stretch #(
    .STRETCH_CYCLES(STRETCH_CYCLES)
  ) u_stretch (
    .clk(clk),
    .reset(reset),
    .cif(cif)
  );

  assign ledOn[PIN_ACT] = linkUp & ~ledOff_q; // [RULE14]
  assign ledOn[PIN_COLL] = cif.ledOn & ~ledOff_q; // [RULE9]
  assign ledOn[PIN_LINK] = linkUp & ~ledOff_q; // [RULE11]
  assign ledOn[PIN_TX] = linkUp & ~ledOff_q; // [RULE11]
  assign ledOn[PIN_RX] = rxActive & ~ledOff_q; // [RULE5]

  // Software reset is deliberately not wired in here, so pins keep
  // driving and the straps are never sampled again.
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin // [RULE13]
    ssl_pin_cell u_cell (
      .clk(clk),
      .reset(reset),
      .capture(capture),
      .driveEn(strapDone_q),
      .ledOn(ledOn[i]),
      .pinIn(ledIn[i]),
      .strap_q(strap[i]),
      .pinOut_q(ledOut[i]),
      .pinOe_q(ledOe[i])
    );
  end

  assign phyAddr = strap; // [RULE3] [RULE4] [RULE14]
  assign ifMode = mode_q;
  assign strapDone = strapDone_q;

  // ****************************************************************
  // Events
  // ****************************************************************
  logic collDly_q;
  logic linkDly_q;
  logic [NUM_EVT-1:0] evt;
  assign evt[EVT_COLL] = collisionDet & ~collDly_q;
  assign evt[EVT_LINK] = strapDone_q & (linkUp ^ linkDly_q);
  assign evt[EVT_STRAP] = capture;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      collDly_q <= 1'b0;
      linkDly_q <= 1'b0;
    end else begin
      collDly_q <= collisionDet;
      linkDly_q <= linkUp;
    end
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // Zero wait states: read data is built in the setup cycle and pready
  // rises for the access cycle.
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [NUM_EVT-1:0] istat_q;
  logic [NUM_EVT-1:0] ien_q;
  logic irq_q;
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_q;
  wire wrAcc = access & pwrite;
  wire hitStrap = (paddr == ADDR_STRAP);
  wire hitLive = (paddr == ADDR_LIVE);
  wire hitIstat = (paddr == ADDR_ISTAT);
  wire hitIclr = (paddr == ADDR_ICLR);
  wire hitIen = (paddr == ADDR_IEN);
  wire hitCtrl = (paddr == ADDR_CTRL);
  wire hitAny = hitStrap | hitLive | hitIstat | hitIclr | hitIen | hitCtrl;
  wire wrIclr = wrAcc & hitIclr;
  wire wrIen = wrAcc & hitIen;
  wire wrCtrl = wrAcc & hitCtrl;
  wire [31:0] strapWord = {22'h0, modeSel_q, speed_q, strapDone_q,
    mode_q, strap};
  wire [31:0] liveWord = {19'h0, ledOe, 3'h0, ledOut};
  wire [31:0] istatWord = {29'h0, istat_q};
  wire [31:0] ienWord = {29'h0, ien_q};
  wire [31:0] ctrlWord = {31'h0, ledOff_q};
  wire [31:0] rdMux = hitStrap ? strapWord :
    hitLive ? liveWord :
    hitIstat ? istatWord :
    hitIen ? ienWord :
    hitCtrl ? ctrlWord : 32'h0;
  wire [NUM_EVT-1:0] clrMask = wrIclr ? pwdata[NUM_EVT-1:0] : ISTAT_RST;
  // A new event in the same cycle as its clear keeps the bit set.
  wire [NUM_EVT-1:0] istatKeep = softReset ? ISTAT_RST : (istat_q & ~clrMask);
  wire [NUM_EVT-1:0] istat_d = istatKeep | evt;
  wire errNext = ~hitAny | (pwrite & (hitStrap | hitLive | hitIstat));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & errNext;
      prdata_q <= (setup & ~pwrite) ? rdMux : 32'h0;
    end
  end

  // ****************************************************************
  // Interrupt and control registers
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      istat_q <= ISTAT_RST;
      ien_q <= IEN_RST;
      ledOff_q <= CTRL_RST;
      irq_q <= 1'b0;
    end else begin
      istat_q <= istat_d;
      irq_q <= |(istat_q & ien_q);
      if (softReset) begin
        ien_q <= IEN_RST;
        ledOff_q <= CTRL_RST;
      end else begin
        if (wrIen) begin
          ien_q <= pwdata[NUM_EVT-1:0];
        end
        if (wrCtrl) begin
          ledOff_q <= pwdata[CTRL_LED_OFF];
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_collRise;
    collisionDet && !collDly_q;
  endsequence

  sequence s_released;
    strapDone_q && !ledOff_q;
  endsequence

  AST_INPUT_IN_RESET: assert property (@(posedge clk) disable iff (reset) // [RULE1]
    !strapDone_q |-> ledOe == '0)
    else $error("Strap pin driven before sampling.");
  AST_DRIVE_AFTER: assert property (@(posedge clk) disable iff (reset) // [RULE1]
    $rose(strapDone_q) |=> ledOe == '1 ##1 ledOe == '1)
    else $error("Pins not turned to outputs after sampling.");
  AST_SAMPLE: assert property (@(posedge clk) disable iff (reset) // [RULE2]
    $rose(strapDone_q) |-> phyAddr == $past(ledIn) && modeSel_q == $past(modeSelectA))
    else $error("Strap address not taken from pins at release.");
  AST_ADDR_HOLD: assert property (@(posedge clk) disable iff (reset) // [RULE4]
    strapDone_q && $past(strapDone_q) |-> $stable(phyAddr) && $stable(mode_q))
    else $error("Strap value changed after sampling.");
  AST_MODE: assert property (@(posedge clk) disable iff (reset) // [RULE6]
    strapDone_q |-> ifMode == (phyAddr[PIN_COLL] ?
      (speed_q ? SSL_SYM_100 : SSL_SER_10) : (speed_q ? SSL_MII_100 : SSL_MII_10)))
    else $error("Interface mode does not match collision strap and speed.");
  AST_COLL_LED: assert property (@(posedge clk) disable iff (reset) // [RULE9]
    (collisionDet and s_released) |=> ledOut[PIN_COLL] == ~phyAddr[PIN_COLL])
    else $error("Collision LED not asserted on collision.");
  AST_LINK_ON: assert property (@(posedge clk) disable iff (reset) // [RULE11]
    (linkUp and s_released) |=> ledOut[PIN_LINK] == ~phyAddr[PIN_LINK]
      && ledOut[PIN_TX] == ~phyAddr[PIN_TX] && ledOut[PIN_ACT] == ~phyAddr[PIN_ACT])
    else $error("Link LEDs not asserted with link up.");
  AST_LINK_OFF: assert property (@(posedge clk) disable iff (reset) // [RULE12]
    !linkUp && strapDone_q |=> ledOut[PIN_LINK] == phyAddr[PIN_LINK]
      && ledOut[PIN_ACT] == phyAddr[PIN_ACT])
    else $error("Link LED not at strap level without link.");
  AST_RX_LED: assert property (@(posedge clk) disable iff (reset) // [RULE5]
    (rxActive and s_released) |=> ledOut[PIN_RX] == ~phyAddr[PIN_RX])
    else $error("Receive LED not asserted with receive activity.");
  AST_SOFT_RESET: assert property (@(posedge clk) disable iff (reset) // [RULE13]
    softReset && strapDone_q && $past(strapDone_q) |=> ledOe == '1 && $stable(phyAddr))
    else $error("Software reset disturbed the strap pins.");
  AST_EVT_SET: assert property (@(posedge clk) disable iff (reset) // [RULE10]
    s_collRise |=> istat_q[EVT_COLL] ##1 (irq || !$past(ien_q[EVT_COLL])))
    else $error("Collision event lost or interrupt wrong.");

  // A dark LED must sit exactly at its strap level, or the board would
  // see a lit indicator on a pin that nothing asserted.
  AST_OE_AFTER_DONE: assert property (@(posedge clk) disable iff (reset) // [RULE1]
    strapDone_q |=> ledOe == '1)
    else $error("Pins not driven after sampling.");
  AST_OUT_IN_RESET: assert property (@(posedge clk) disable iff (reset) // [RULE1]
    !strapDone_q |-> ledOut == '0)
    else $error("Pin drive value not quiet before sampling.");
  AST_COLL_IDLE: assert property (@(posedge clk) disable iff (reset) // [RULE9]
    !cif.ledOn && strapDone_q |=> ledOut[PIN_COLL] == phyAddr[PIN_COLL])
    else $error("Collision LED lit with no collision.");
  AST_TX_OFF: assert property (@(posedge clk) disable iff (reset) // [RULE11]
    !linkUp && strapDone_q |=> ledOut[PIN_TX] == phyAddr[PIN_TX])
    else $error("Transmit LED lit without link.");
  AST_RX_OFF: assert property (@(posedge clk) disable iff (reset) // [RULE5]
    !rxActive && strapDone_q |=> ledOut[PIN_RX] == phyAddr[PIN_RX])
    else $error("Receive LED lit without receive activity.");
  AST_LEDS_OFF: assert property (@(posedge clk) disable iff (reset) // [RULE12]
    ledOff_q && strapDone_q |=> ledOut == phyAddr)
    else $error("LED lit while all LEDs are switched off.");
  // Strap capture, the strap and link events, and the interface mode under software reset.
  AST_ACT_ADDR: assert property (@(posedge clk) disable iff (reset) // [RULE14]
    $rose(strapDone_q) |-> phyAddr[PIN_ACT] == $past(ledIn[PIN_ACT]))
    else $error("Address bit 0 not taken from the activity pin.");
  AST_LINK_ADDR: assert property (@(posedge clk) disable iff (reset) // [RULE3]
    $rose(strapDone_q) |-> phyAddr[PIN_LINK] == $past(ledIn[PIN_LINK])
      && phyAddr[PIN_TX] == $past(ledIn[PIN_TX]))
    else $error("Address bits 2 and 3 not taken from their pins.");
  AST_RX_ADDR: assert property (@(posedge clk) disable iff (reset) // [RULE4]
    $rose(strapDone_q) |-> phyAddr[PIN_RX] == $past(ledIn[PIN_RX]))
    else $error("Address bit 4 not taken from the receive pin.");
  AST_MODE_MII: assert property (@(posedge clk) disable iff (reset) // [RULE7]
    strapDone_q && !phyAddr[PIN_COLL] |-> ifMode == SSL_MII_10 || ifMode == SSL_MII_100)
    else $error("Low collision strap did not select the media independent interface.");
  AST_MODE_STREAM: assert property (@(posedge clk) disable iff (reset) // [RULE8]
    strapDone_q && phyAddr[PIN_COLL] |-> ifMode == SSL_SER_10 || ifMode == SSL_SYM_100)
    else $error("High collision strap did not select the stream interface.");
  AST_STRAP_EVT: assert property (@(posedge clk) disable iff (reset) // [RULE2]
    $rose(strapDone_q) |-> istat_q[EVT_STRAP])
    else $error("Strap done event not recorded.");
  AST_LINK_EVT: assert property (@(posedge clk) disable iff (reset) // [RULE11]
    strapDone_q && $changed(linkUp) |=> istat_q[EVT_LINK])
    else $error("Link change event not recorded.");
  AST_SOFT_MODE: assert property (@(posedge clk) disable iff (reset) // [RULE13]
    softReset && strapDone_q |=> $stable(ifMode) && strapDone_q)
    else $error("Software reset disturbed the interface mode.");
endmodule
`default_nettype wire

// ---- verification/ssl_board_model.sv ----
// Board model of the strap resistors and status LEDs on the multiplexed pins.
`default_nettype none
module ssl_board_model
  import ssl_pkg::*;
(
  input wire logic [NUM_PINS-1:0] strapLvl,
  input wire logic [NUM_PINS-1:0] ledOut,
  input wire logic [NUM_PINS-1:0] ledOe,
  output logic [NUM_PINS-1:0] ledIn,
  output logic [NUM_PINS-1:0] lit
);
  timeunit 1ns;
  timeprecision 1ps;
  // **************************************************************
  // Pin wires
  // **************************************************************
  // A released pin settles to its resistor level, so sampling never sees a float.
  assign ledIn = (ledOe & ledOut) | (~ledOe & strapLvl);
  // The LED hangs towards the far rail, so it lights only when driven away from the strap.
  assign lit = ledOe & (ledOut ^ strapLvl);
endmodule
`default_nettype wire

// ---- verification/strap_sample_led_drive_tb.sv ----
// Self-checking bench of the strap sampling and LED drive block.
`default_nettype none
module strap_sample_led_drive_tb
  import ssl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned STRETCH = 20;
  localparam int LIMIT = 20000;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic speedSelect = 1'h0, modeSelectA = 1'h0, softReset = 1'h0;
  logic collisionDet = 1'h0, linkUp = 1'h0, rxActive = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, strapDone, irq;
  logic [NUM_PINS-1:0] strapLvl = 5'h15, ledIn, ledOut, ledOe, phyAddr, lit;
  ssl_mode_t ifMode;
  int n_errors = 0, total_checks = 0, cycles = 0;

`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end

  // **************************************************************
  // Design, board and clock
  // **************************************************************
  ssl_top #(.STRETCH_CYCLES(STRETCH)) dut (.clk(clk), .reset(reset), .ledIn(ledIn),
    .ledOut(ledOut), .ledOe(ledOe), .speedSelect(speedSelect), .modeSelectA(modeSelectA),
    .softReset(softReset), .collisionDet(collisionDet), .linkUp(linkUp),
    .rxActive(rxActive), .phyAddr(phyAddr), .ifMode(ifMode), .strapDone(strapDone),
    .irq(irq), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ssl_board_model board (.strapLvl(strapLvl), .ledOut(ledOut), .ledOe(ledOe),
    .ledIn(ledIn), .lit(lit));

  initial begin
    forever #10 clk = ~clk;
  end

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      wrap_up();
    end
  end

  // **************************************************************
  // Tasks
  // **************************************************************
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // The trailing idle edge keeps two calls from driving psel twice in one step.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task automatic pulse_coll();
    collisionDet <= 1'h1;
    @(posedge clk);
    collisionDet <= 1'h0;
    @(posedge clk);
  endtask

  task automatic hw_reset(input logic [4:0] s, input logic sp, input logic ms);
    reset <= 1'h1;
    strapLvl <= s;
    speedSelect <= sp;
    modeSelectA <= ms;
    repeat (16) @(posedge clk);
    `CHK(ledOe, 5'h00)
    reset <= 1'h0;
    do @(posedge clk); while (strapDone !== 1'h1);
    repeat (2) @(posedge clk);
    `CHK(ledOe, 5'h1F)
    `CHK(phyAddr, s)
    `CHK(ifMode, ssl_mode_t'({s[PIN_COLL], sp}))
    apb(1'h0, ADDR_STRAP, 32'h0);
    `CHK(rd, {22'h0, ms, sp, 1'h1, s[PIN_COLL], sp, s})
  endtask

  // **************************************************************
  // Main sequence
  // **************************************************************
  initial begin
    for (int k = 0; k < 4; k++) begin
      hw_reset({k[0], 1'h1, ~k[0], k[1], k[0] ^ k[1]}, k[0], ~k[0]);
    end
    linkUp <= 1'h1;
    rxActive <= 1'h1;
    repeat (2) @(posedge clk);
    `CHK(lit, 5'h1D)
    linkUp <= 1'h0;
    rxActive <= 1'h0;
    repeat (2) @(posedge clk);
    `CHK(lit, 5'h00)
    linkUp <= 1'h1;
    pulse_coll();
    `CHK(ledOut[PIN_COLL], ~strapLvl[PIN_COLL])
    repeat (STRETCH - 1) @(posedge clk);
    `CHK(lit[PIN_COLL], 1'h1)
    repeat (4) @(posedge clk);
    `CHK(lit[PIN_COLL], 1'h0)
    pulse_coll();
    repeat (10) @(posedge clk);
    pulse_coll();
    repeat (STRETCH - 1) @(posedge clk);
    `CHK(lit[PIN_COLL], 1'h1)
    repeat (4) @(posedge clk);
    `CHK(lit[PIN_COLL], 1'h0)
    // Lit LEDs drive the pins away from the straps, so a resample would alter the address.
    softReset <= 1'h1;
    repeat (4) @(posedge clk);
    `CHK(ledOe, 5'h1F)
    softReset <= 1'h0;
    @(posedge clk);
    `CHK(phyAddr, strapLvl)
    apb(1'h1, ADDR_ICLR, 32'h7);
    apb(1'h1, ADDR_IEN, 32'h1);
    `CHK(irq, 1'h0)
    pulse_coll();
    repeat (3) @(posedge clk);
    `CHK(irq, 1'h1)
    apb(1'h1, ADDR_ICLR, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'h0)
    apb(1'h1, ADDR_IEN, 32'h0);
    pulse_coll();
    repeat (3) @(posedge clk);
    `CHK(irq, 1'h0)
    apb(1'h0, ADDR_ISTAT, 32'h0);
    `CHK(rd[EVT_COLL], 1'h1)
    apb(1'h0, 8'h40, 32'h0);
    `CHK(err, 1'h1)
    apb(1'h1, ADDR_STRAP, 32'hFFFFFFFF);
    `CHK(err, 1'h1)
    apb(1'h0, ADDR_STRAP, 32'h0);
    `CHK(rd[4:0], strapLvl)
    repeat (STRETCH + 4) @(posedge clk);
    apb(1'h1, ADDR_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(ledOut, strapLvl)
    apb(1'h1, ADDR_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(lit, 5'h0D)
    apb(1'h0, ADDR_LIVE, 32'h0);
    `CHK(rd, {19'h0, 5'h1F, 3'h0, strapLvl ^ 5'h0D})
    wrap_up();
  end
endmodule
`default_nettype wire
